//--- hw/release_delay.sv
// one reset release delay: holds its output asserted while the source
// is active and for a set count of clocks after the source goes away.
// assumes srcActive is already synchronised to mclk.
`timescale 1ns/1ps
module release_delay #(
  parameter int unsigned DELAY_CLKS = 40000
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic srcActive,
  output logic holdReset
);

  // counter wide enough for the full delay
  localparam int unsigned CW = $clog2(DELAY_CLKS + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CLKS - 1);

  logic [CW-1:0] count_ff; // clocks spent since release
  logic hold_ff; // reset held
  logic [CW-1:0] nxt_count;
  logic nxt_hold;
  wire doneCount = (count_ff == LAST);

  // restart on every source assertion, no delay on reasserting
  assign nxt_count = srcActive ? '0 :
                     (hold_ff ? count_ff + CW'(1) : count_ff);
  assign nxt_hold = srcActive ? 1'b1 : (hold_ff & ~doneCount);

  // counting only runs while the hold is still in force
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_ff <= '0;
      hold_ff <= 1'b1;
    end else begin
      count_ff <= nxt_count;
      hold_ff <= nxt_hold;
    end
  end

  assign holdReset = hold_ff;

endmodule : release_delay

//--- hw/watchdog_with_reset_delays.sv
// watchdog timer with power-on and brown-out release delays.
// assumes an 8-bit register port on mclk, and detector, idle and
// power-down levels from outside the clock domain.
// full periods run to millions of clocks; the count byte is readable.
`timescale 1ns/1ps
`include "watchdog_consts.svh"
module watchdog_with_reset_delays #(
  parameter int unsigned RELEASE_CLKS = `RELEASE_DELAY_CLKS
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic porActive,
  input wire logic brownoutDetect,
  input wire logic idleMode,
  input wire logic powerDown,
  input wire logic rstPinIn,
  output logic rstPinOut,
  output logic rstPinOe,
  output logic coreReset,
  output logic irq
);

  // pin, detector, idle and power-down synchronisers, two stages each; the detectors and
  // the pin change at any time, so no logic may read the first stage
  logic [1:0] porSync_ff;
  logic [1:0] bodSync_ff;
  logic [1:0] idleSync_ff;
  logic [1:0] pdSync_ff;
  logic [1:0] pinSync_ff;

  // only the second stage is read by logic
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      porSync_ff <= 2'h3;
      bodSync_ff <= 2'h0;
      idleSync_ff <= 2'h0;
      pdSync_ff <= 2'h0;
      pinSync_ff <= 2'h0;
    end else begin
      porSync_ff <= {porSync_ff[0], porActive};
      bodSync_ff <= {bodSync_ff[0], brownoutDetect};
      idleSync_ff <= {idleSync_ff[0], idleMode};
      pdSync_ff <= {pdSync_ff[0], powerDown};
      pinSync_ff <= {pinSync_ff[0], rstPinIn};
    end
  end

  wire porLvl = porSync_ff[1]; // power-on detector active
  wire bodLvl = bodSync_ff[1]; // brown-out active
  wire idleLvl = idleSync_ff[1]; // cpu idle
  wire pdLvl = pdSync_ff[1]; // power-down
  wire pinLvl = pinSync_ff[1]; // board reset line seen on the pin

  // release delays, one instance per detector; a brown-out that comes
  // during the power-on hold restarts only its own count
  logic porHold;
  logic bodHold;

  release_delay #(.DELAY_CLKS(RELEASE_CLKS)) u_por_delay (
    .mclk(mclk),
    .rstn(rstn),
    .srcActive(porLvl),
    .holdReset(porHold)
  );

  release_delay #(.DELAY_CLKS(RELEASE_CLKS)) u_bod_delay (
    .mclk(mclk),
    .rstn(rstn),
    .srcActive(bodLvl),
    .holdReset(bodHold)
  );

  // cold reset: power-on level or hold; warm: brown-out level or hold, or the pin
  wire coldReset = porHold | porLvl;
  wire warmReset = bodHold | bodLvl | pinLvl;

  // register state
  logic [7:0] ctrl_ff; // watchdog control
  logic [7:0] power_control_ff; // power control
  logic [7:0] irqStat_ff; // sticky event bits
  logic [7:0] irqMask_ff; // interrupt mask
  logic [7:0] rdata_ff; // read data, one cycle after the strobe
  logic hwRun_ff; // armed in hardware mode
  watchdog_pkg::key_state_t keyState_ff; // key recogniser

  // machine-cycle prescaler and watchdog count
  logic [3:0] mcDiv_ff;
  logic [20:0] wdCount_ff;
  logic [4:0] pulseCnt_ff; // remaining clocks of the timeout pulse
  logic pulsePin_ff; // pulse also goes out on the pin
  logic coreReset_ff;
  logic rstPinOut_ff;
  logic rstPinOe_ff;
  logic irq_ff;

  // address decode
  wire selKey = (regAddr == `ADDR_RESTART_KEY);
  wire selCtrl = (regAddr == `ADDR_WDOG_CTRL);
  wire selPcon = (regAddr == `ADDR_POWER_CTRL);
  wire selStat = (regAddr == `ADDR_IRQ_STATUS);
  wire selMask = (regAddr == `ADDR_IRQ_MASK);
  wire selWstat = (regAddr == `ADDR_WDOG_STATUS);
  wire wrKey = regWr & selKey;
  wire wrCtrl = regWr & selCtrl;
  // write strobes per register
  wire wrPcon = regWr & selPcon; // power control write
  wire wrStat = regWr & selStat; // status write-one-to-clear
  wire wrMask = regWr & selMask; // mask write
  wire selCount = (regAddr == `ADDR_WDOG_COUNT); // count low byte

  // control fields
  wire [2:0] periodSel = ctrl_ff[7:`CTRL_PS_LSB];
  wire idleFreeze = ctrl_ff[`CTRL_IDLE_FREEZE];
  wire pinRstDis = ctrl_ff[`CTRL_PIN_RST_DIS];
  wire hwMode = ctrl_ff[`CTRL_HW_MODE];
  wire softRestart = ctrl_ff[`CTRL_SOFT_RESTART];
  wire softEnable = ctrl_ff[`CTRL_SOFT_ENABLE];

  // machine cycle tick every 12 clocks; the watchdog never sees the
  // raw oscillator, so x2 mode only changes the mcycle source upstream
  wire mcTick = (mcDiv_ff == 4'(`MCYCLE_CLKS - 1));

  // key sequence: second byte must be the very next key write
  wire keyDone = wrKey & (keyState_ff == watchdog_pkg::KEY_GOT_FIRST) &
                 (regWdata == `KEY_SECOND);
  wire armNow = keyDone & hwMode;

  // running: software enable, or armed in hardware mode
  wire running = hwMode ? hwRun_ff : softEnable;
  // idle freeze and power-down stop the count
  // power-down gates the count even while mclk keeps running
  wire frozen = pdLvl | (idleLvl & idleFreeze);
  wire countEn = running & ~frozen & mcTick;

  // timeout index: bit 13 plus select, 16K doubling per step
  wire [4:0] topBit = 5'(`WDOG_BASE_LOG2 - 1) + {2'h0, periodSel};
  wire [20:0] lastCount = (21'h1 << topBit) * 21'h2 - 21'h1;
  wire timeout = countEn & (wdCount_ff >= lastCount);
  // service in software mode only; restart bit inert in hardware mode
  wire swRestart = ~hwMode & softRestart;
  wire clearCount = swRestart | keyDone;
  // an armed watchdog keeps hardware mode until a reset: clearing the
  // mode bit must not become a back door that stops it
  wire keepHw = regWdata[`CTRL_HW_MODE] | hwRun_ff;
  // in hardware mode the enable bit is status, not a control
  wire keepEn = hwMode ? softEnable : regWdata[`CTRL_SOFT_ENABLE];
  wire [7:0] ctrlWrite = {regWdata[7:3], keepHw, regWdata[1], keepEn};

  // read mux; enable bit reports running state in hardware mode
  // unmapped addresses read zero; the count byte shows progress
  wire [7:0] ctrlView = {ctrl_ff[7:1],
                         hwMode ? hwRun_ff : softEnable};
  wire [7:0] wstatView = {5'h0, coreReset_ff, hwRun_ff, running};
  wire [7:0] rdMux = selCtrl ? ctrlView :
                     selPcon ? power_control_ff :
                     selStat ? irqStat_ff :
                     selMask ? irqMask_ff :
                     selWstat ? wstatView :
                     selCount ? wdCount_ff[7:0] : 8'h00;

  // events into the sticky status register
  wire [7:0] irqEvents = {5'h0, bodLvl, porLvl, timeout};
  wire [7:0] statClr = wrStat ? regWdata : 8'h00;

  // prescaler runs free; counts mclk to machine cycles
  // free running means the first tick after enabling may come early
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mcDiv_ff <= 4'h0;
    end else begin
      mcDiv_ff <= mcTick ? 4'h0 : mcDiv_ff + 4'h1;
    end
  end

  // watchdog count; disabling only freezes, never clears
  // 21 bits: the longest period ends at all ones, so no carry is lost
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wdCount_ff <= 21'h0;
    end else if (coldReset | warmReset | clearCount | timeout) begin
      wdCount_ff <= 21'h0;
    end else if (countEn) begin
      wdCount_ff <= wdCount_ff + 21'h1;
    end
  end

  // control register; all zero on any reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= `CTRL_RESET;
    end else if (coldReset | warmReset | coreReset_ff) begin
      ctrl_ff <= `CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_ff <= ctrlWrite;
    end else if (swRestart) begin
      ctrl_ff[`CTRL_SOFT_RESTART] <= 1'b0;
    end
  end

  // hardware arm flag; only a reset drops it
  // the timeout pulse counts as a reset, so arming starts over
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hwRun_ff <= 1'b0;
    end else if (coldReset | warmReset | coreReset_ff) begin
      hwRun_ff <= 1'b0;
    end else if (armNow) begin
      hwRun_ff <= 1'b1;
    end
  end

  // key recogniser: any other key value drops a half sequence
  // writes to other addresses leave a half sequence alone
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      keyState_ff <= watchdog_pkg::KEY_IDLE;
    end else if (wrKey) begin
      keyState_ff <= (regWdata == `KEY_FIRST) ?
                     watchdog_pkg::KEY_GOT_FIRST :
                     watchdog_pkg::KEY_IDLE;
    end
  end

  // power control: cold reset sets the flag, software clears it;
  // a cold reset in the cycle of a clearing write wins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      power_control_ff <= `POWER_CONTROL_RESET;
    end else if (coldReset) begin
      power_control_ff[`POWER_CONTROL_POF_BIT] <= 1'b1;
    end else if (wrPcon) begin
      power_control_ff <= regWdata;
    end
  end

  // sticky status, write one to clear; an event in the same cycle as
  // its clear wins, so software never loses an event it did not see
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irqStat_ff <= `IRQ_RESET;
    end else begin
      irqStat_ff <= (irqStat_ff & ~statClr) | irqEvents;
    end
  end

  // interrupt mask, plain read-write
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irqMask_ff <= `IRQ_RESET;
    end else if (wrMask) begin
      irqMask_ff <= regWdata;
    end
  end

  // timeout pulse: fixed width; pin driven only when enabled
  // the width outlasts the pin synchroniser, so the board sees it too
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pulseCnt_ff <= 5'h0;
      pulsePin_ff <= 1'b0;
    end else if (timeout) begin
      pulseCnt_ff <= 5'(`WDOG_PULSE_CLKS);
      pulsePin_ff <= ~pinRstDis;
    end else if (pulseCnt_ff != 5'h0) begin
      pulseCnt_ff <= pulseCnt_ff - 5'h1;
    end else begin
      pulsePin_ff <= 1'b0;
    end
  end

  wire pulseOn = (pulseCnt_ff != 5'h0);
  wire pinDrive = pulseOn & pulsePin_ff;
  wire irqPending = |(irqStat_ff & irqMask_ff); // unmasked event

  // core reset: every reset source and the timeout pulse hold the core
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      coreReset_ff <= 1'b1;
    end else begin
      coreReset_ff <= coldReset | warmReset | pulseOn;
    end
  end

  // pin driver: level and enable move together, so this block only
  // ever drives the line high and never fights a board pull-down
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstPinOut_ff <= 1'b0;
      rstPinOe_ff <= 1'b0;
    end else begin
      rstPinOut_ff <= pinDrive;
      rstPinOe_ff <= pinDrive;
    end
  end

  // level interrupt while any unmasked status bit is set
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= irqPending;
    end
  end

  // read data stand for one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= regRd ? rdMux : 8'h00;
    end
  end

  assign regRdata = rdata_ff;
  assign coreReset = coreReset_ff;
  assign rstPinOut = rstPinOut_ff;
  assign rstPinOe = rstPinOe_ff;
  assign irq = irq_ff;

endmodule : watchdog_with_reset_delays

//--- shared/watchdog_consts.svh
// constants for the watchdog block: register addresses, field positions,
// reset values and timing counts. the CPU clock is 20 MHz on mclk.
`ifndef WATCHDOG_CONSTS_SVH
`define WATCHDOG_CONSTS_SVH

// register addresses (8-bit SFR-style space)
`define ADDR_RESTART_KEY 8'hA6
`define ADDR_WDOG_CTRL 8'hA7
`define ADDR_POWER_CTRL 8'h87
`define ADDR_IRQ_STATUS 8'hF0
`define ADDR_IRQ_MASK 8'hF1
`define ADDR_WDOG_STATUS 8'hF2
// low byte of the watchdog count, read only
`define ADDR_WDOG_COUNT 8'hF3

// watchdog control field positions
`define CTRL_PS_LSB 5
`define CTRL_IDLE_FREEZE 4
`define CTRL_PIN_RST_DIS 3
`define CTRL_HW_MODE 2
`define CTRL_SOFT_RESTART 1
`define CTRL_SOFT_ENABLE 0
`define CTRL_RESET 8'h00

// power control: power-off flag position
`define POWER_CONTROL_POF_BIT 4
// power control reads with the power-off flag set after a cold start
`define POWER_CONTROL_RESET 8'h10

// interrupt status bits
`define IRQ_TIMEOUT 0
`define IRQ_POR 1
`define IRQ_BROWNOUT 2
`define IRQ_RESET 8'h00

// restart key bytes
`define KEY_FIRST 8'h1E
`define KEY_SECOND 8'hE1

// machine cycle: 12 clock periods of mclk
`define MCYCLE_CLKS 12
// base watchdog period, 16K machine cycles
`define WDOG_BASE_LOG2 14
// pulse width of the watchdog reset, in mclk cycles
`define WDOG_PULSE_CLKS 24

// release delay after power-on or brown-out: 2 ms at 20 MHz
`define RELEASE_DELAY_US 2000
`define CLK_MHZ 20
`define RELEASE_DELAY_CLKS (`RELEASE_DELAY_US * `CLK_MHZ)

`endif

//--- shared/watchdog_pkg.sv
// types for the watchdog block.
// assumes the constants header is included by the design files.
package watchdog_pkg;

  // key recogniser state
  typedef enum logic [0:0] {
    KEY_IDLE = 1'b0,
    KEY_GOT_FIRST = 1'b1
  } key_state_t;

endpackage : watchdog_pkg

//--- tb/board_reset_line.sv
// board side of the two-way reset pin: resolves the wire level.
// assumes a pull-down on the board and an optional push-button source.
`timescale 1ns/1ps
module board_reset_line (
  input wire logic rstPinOut,
  input wire logic rstPinOe,
  input wire logic boardPush,
  output logic pinLevel
);
  // wired-or: the device drives only high, the pull-down wins otherwise
  assign pinLevel = (rstPinOe & rstPinOut) | boardPush;
endmodule : board_reset_line

//--- tb/tb_watchdog_with_reset_delays.sv
// testbench for the watchdog block: register bus scenarios and resets.
// assumes a short release count; full watchdog periods are too long here.
`timescale 1ns/1ps
`include "watchdog_consts.svh"
module tb_watchdog_with_reset_delays;
  localparam int REL = 20; // shortened release delay
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic porActive = 1'b0;
  logic brownoutDetect = 1'b0;
  logic boardPush = 1'b0; // push-button on the board reset line
  logic idleMode = 1'b0; // cpu idle level
  logic powerDown = 1'b0; // power-down level
  logic [7:0] q0; // earlier read result
  logic [7:0] regRdata;
  logic rstPinIn, rstPinOut, rstPinOe, coreReset, irq;
  logic [7:0] q; // last read result
  logic ia, ib;
  int n;
  int mismatches = 0;
  int n_checks = 0;
  // 20 MHz clock
  always #25 mclk = ~mclk;
  watchdog_with_reset_delays #(.RELEASE_CLKS(REL)) dut_u (.mclk(mclk),
    .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .porActive(porActive),
    .brownoutDetect(brownoutDetect), .idleMode(idleMode),
    .powerDown(powerDown),
    .rstPinIn(rstPinIn), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
    .coreReset(coreReset), .irq(irq));
  board_reset_line board_u (.rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
    .boardPush(boardPush), .pinLevel(rstPinIn));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 q = regRdata;
  endtask : rd
  // bounded wait for the core reset to drop, counting cycles
  task automatic wait_free();
    n = 0;
    while (coreReset !== 1'b0 && n < 200) begin
      @(posedge mclk);
      #1 n++;
    end
    check({7'h00, coreReset}, 8'h00);
  endtask : wait_free
  task automatic t_reset();
    rd(`ADDR_WDOG_CTRL);
    check(q, `CTRL_RESET);
    rd(`ADDR_POWER_CTRL);
    check(q & 8'h10, 8'h10);
    rd(`ADDR_RESTART_KEY);
    check(q, 8'h00);
    rd(8'h55); // unmapped place
    check(q, 8'h00);
    wr(`ADDR_WDOG_CTRL, 8'hF8);
    rd(`ADDR_WDOG_CTRL);
    check(q, 8'hF8);
    wr(`ADDR_WDOG_CTRL, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_soft();
    wr(`ADDR_WDOG_CTRL, 8'h01);
    rd(`ADDR_WDOG_STATUS);
    check(q & 8'h01, 8'h01);
    wr(`ADDR_WDOG_CTRL, 8'h03);
    rd(`ADDR_WDOG_CTRL);
    check(q, 8'h01);
    wr(`ADDR_WDOG_CTRL, 8'h00);
    rd(`ADDR_WDOG_STATUS);
    check(q & 8'h01, 8'h00);
    $display("test soft done");
  endtask : t_soft
  task automatic t_hw();
    wr(`ADDR_WDOG_CTRL, 8'h06);
    rd(`ADDR_WDOG_CTRL);
    check(q, 8'h06);
    wr(`ADDR_RESTART_KEY, `KEY_FIRST);
    wr(`ADDR_RESTART_KEY, 8'h55);
    wr(`ADDR_RESTART_KEY, `KEY_SECOND);
    rd(`ADDR_WDOG_STATUS);
    check(q & 8'h02, 8'h00);
    wr(`ADDR_RESTART_KEY, `KEY_FIRST);
    wr(`ADDR_RESTART_KEY, `KEY_SECOND);
    rd(`ADDR_WDOG_STATUS);
    check(q & 8'h03, 8'h03);
    rd(`ADDR_WDOG_CTRL);
    check(q & 8'h01, 8'h01);
    wr(`ADDR_WDOG_CTRL, 8'h04);
    rd(`ADDR_WDOG_STATUS);
    check(q & 8'h01, 8'h01);
    wr(`ADDR_WDOG_CTRL, 8'h00);
    rd(`ADDR_WDOG_STATUS);
    check(q & 8'h03, 8'h03);
    rd(`ADDR_WDOG_CTRL);
    check(q & 8'h05, 8'h05);
    @(posedge mclk);
    boardPush <= 1'b1;
    repeat (4) @(posedge mclk);
    boardPush <= 1'b0;
    wait_free();
    rd(`ADDR_WDOG_STATUS);
    check(q & 8'h03, 8'h00);
    $display("test hw done");
  endtask : t_hw
  task automatic t_bod_irq();
    @(posedge mclk);
    brownoutDetect <= 1'b1;
    repeat (6) @(posedge mclk);
    check({7'h00, coreReset}, 8'h01);
    brownoutDetect <= 1'b0;
    wait_free();
    check({7'h00, n >= REL && n <= REL + 6}, 8'h01);
    rd(`ADDR_IRQ_STATUS);
    check(q & 8'h04, 8'h04);
    wr(`ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(posedge mclk);
    ia = irq;
    wr(`ADDR_IRQ_MASK, 8'hFF);
    repeat (2) @(posedge mclk);
    ib = irq;
    check({7'h00, ia}, 8'h00);
    check({7'h00, ib}, 8'h01);
    wr(`ADDR_IRQ_STATUS, 8'hFF);
    repeat (2) @(posedge mclk);
    check({7'h00, irq}, 8'h00);
    rd(`ADDR_IRQ_STATUS);
    check(q, 8'h00);
    $display("test brownout done");
  endtask : t_bod_irq
  task automatic t_por();
    wr(`ADDR_POWER_CTRL, 8'h00);
    wr(`ADDR_WDOG_CTRL, 8'h01);
    rd(`ADDR_POWER_CTRL);
    check(q & 8'h10, 8'h00);
    @(posedge mclk);
    porActive <= 1'b1;
    repeat (6) @(posedge mclk);
    check({7'h00, coreReset}, 8'h01);
    porActive <= 1'b0;
    wait_free();
    check({7'h00, n >= REL && n <= REL + 6}, 8'h01);
    rd(`ADDR_POWER_CTRL);
    check(q & 8'h10, 8'h10);
    rd(`ADDR_WDOG_STATUS);
    check(q & 8'h01, 8'h00);
    check({6'h00, rstPinOut, rstPinOe}, 8'h00);
    $display("test por done");
  endtask : t_por
  // count readback: tick rate, freeze on disable, idle, power-down
  task automatic t_count();
    wr(`ADDR_WDOG_CTRL, 8'h03);
    repeat (120) @(posedge mclk);
    rd(`ADDR_WDOG_COUNT);
    check({7'h00, q >= 8'h09 && q <= 8'h0B}, 8'h01);
    wr(`ADDR_WDOG_CTRL, 8'h00);
    rd(`ADDR_WDOG_COUNT);
    q0 = q;
    repeat (60) @(posedge mclk);
    rd(`ADDR_WDOG_COUNT);
    check(q, q0);
    check({7'h00, q0 >= 8'h0A}, 8'h01);
    @(posedge mclk);
    idleMode <= 1'b1;
    wr(`ADDR_WDOG_CTRL, 8'h11);
    rd(`ADDR_WDOG_COUNT);
    q0 = q;
    repeat (60) @(posedge mclk);
    rd(`ADDR_WDOG_COUNT);
    check(q, q0);
    wr(`ADDR_WDOG_CTRL, 8'h01);
    repeat (60) @(posedge mclk);
    rd(`ADDR_WDOG_COUNT);
    check({7'h00, q >= q0 + 8'h04}, 8'h01);
    @(posedge mclk);
    powerDown <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(`ADDR_WDOG_COUNT);
    q0 = q;
    repeat (60) @(posedge mclk);
    rd(`ADDR_WDOG_COUNT);
    check(q, q0);
    @(posedge mclk);
    powerDown <= 1'b0;
    idleMode <= 1'b0;
    wr(`ADDR_WDOG_CTRL, 8'h03);
    rd(`ADDR_WDOG_COUNT);
    check({7'h00, q <= 8'h01}, 8'h01);
    wr(`ADDR_WDOG_CTRL, 8'h00);
    $display("test count done");
  endtask : t_count
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  // watchdog on the bench itself: the tests need well under 2000 cycles
  initial begin
    #(20000 * 50);
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    wait_free();
    t_reset();
    t_soft();
    t_count();
    t_hw();
    t_bod_irq();
    t_por();
    complete_run();
  end
endmodule : tb_watchdog_with_reset_delays

//--- tb/watchdog_props.sv
// port checker for the watchdog block, single mclk domain.
// assumes it is bound onto the top module with the same release count.
`timescale 1ns/1ps
`include "watchdog_consts.svh"
module watchdog_props #(
  parameter int unsigned RELEASE_CLKS = 20
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic porActive,
  input wire logic brownoutDetect,
  input wire logic rstPinIn,
  input wire logic rstPinOut,
  input wire logic rstPinOe,
  input wire logic coreReset,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // control write carrying the restart bit, outside any reset
  sequence wr_restart_s(logic hw);
    regWr && regAddr == `ADDR_WDOG_CTRL && regWdata[1] &&
      regWdata[2] == hw && !coreReset;
  endsequence
  sequence rd_ctrl_s;
    regRd && regAddr == `ADDR_WDOG_CTRL;
  endsequence
  // brown-out long enough to pass the synchroniser, then gone
  sequence bod_pulse_s;
    brownoutDetect [*4] ##1 !brownoutDetect;
  endsequence
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_key_reads_zero: assert property (regRd &&
    regAddr == `ADDR_RESTART_KEY |=> regRdata == 8'h00)
    else $error("restart key read not zero");
  a_por_reset: assert property (porActive |-> ##[0:4] coreReset)
    else $error("power-on did not reset core");
  a_bod_reset: assert property (brownoutDetect |-> ##[0:4] coreReset)
    else $error("brown-out did not reset core");
  a_bod_hold: assert property (bod_pulse_s |-> coreReset [*8])
    else $error("core released too early after brown-out");
  a_pin_high: assert property (rstPinOe |-> rstPinOut)
    else $error("reset pin driven low");
  a_pin_cause: assert property ($rose(rstPinOe) |-> ##[0:2] coreReset)
    else $error("reset pin driven without core reset");
  a_soft_selfclr: assert property (wr_restart_s(1'b0) ##2 rd_ctrl_s
    |=> !regRdata[1])
    else $error("soft restart bit not cleared");
  a_hw_sticks: assert property (wr_restart_s(1'b1) ##2 rd_ctrl_s
    |=> regRdata[1])
    else $error("soft restart bit cleared in hardware mode");
  a_irq_clear: assert property (regWr && regAddr == `ADDR_IRQ_STATUS &&
    regWdata == 8'hFF && !porActive && !brownoutDetect && !rstPinIn &&
    !coreReset |-> ##2 !irq)
    else $error("irq still high after clearing all status");
endmodule : watchdog_props

bind watchdog_with_reset_delays watchdog_props #(
  .RELEASE_CLKS(RELEASE_CLKS)
) props_u (.mclk(mclk), .rstn(rstn), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .porActive(porActive), .brownoutDetect(brownoutDetect),
  .rstPinIn(rstPinIn), .rstPinOut(rstPinOut), .rstPinOe(rstPinOe),
  .coreReset(coreReset), .irq(irq));
